// ===== capture_irq_consts.svh
`ifndef CAPTURE_IRQ_CONSTS_SVH
`define CAPTURE_IRQ_CONSTS_SVH

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define ADDR_FIELD_COUNTER   12'h0e8
`define ADDR_INT_STATUS      12'h100
`define ADDR_INT_MASK        12'h104
`define ADDR_CAPTURE_CTRL    12'h108
`define ADDR_DMA_CTRL        12'h10c

// ------------------------------------------------------------
// Status field positions
// ------------------------------------------------------------
`define ST_PROG_HI           31
`define ST_PROG_LO           28
`define ST_DMA_RUN           27
`define ST_ACK               25
`define ST_FIELD             24
`define ST_SYNC_ERR          19
`define ST_OPCODE_ERR        18
`define ST_ABORT             17
`define ST_INSTR_PAR         16
`define ST_BUS_PAR           15
`define ST_RESYNC            14
`define ST_OVR_TARGET        13
`define ST_OVR_DROP          12
`define ST_PROG_IRQ          11
`define ST_AUX_PIN           9
`define ST_SERIAL_DONE       8
`define ST_PRESENCE          5
`define ST_HORIZ_LOCK_CHANGE             4
`define ST_CONV_OVF          3
`define ST_LINE              2
`define ST_FIELD_CHG         1
`define ST_STD_CHG           0

// ------------------------------------------------------------
// Widths, masks and reset values
// ------------------------------------------------------------
`define STICKY_VALID         23'h0ffb3f
`define MASK_IRQ_BITS        22
`define MASK_COMPAT_BIT      23
`define FIELD_CNT_RESET      8'h00
`define MASK_RESET           24'h000000
`define PROG_STATUS_RESET    4'h0
`define CAP_EN_RESET         2'h0
`define DMA_EN_BIT           1
`define CAP_EN_HI            1
`define ZERO_WORD            32'h00000000

`endif

// ===== capture_irq_pkg.sv
package capture_irq_pkg;
   typedef logic [22:0] sticky_t;
   typedef logic [31:0] word_t;
endpackage

// ===== capture_interrupt_status_unit.sv
// Function
// - Field counter counts field changes while any capture enable is set.
// - Any write clears the field counter; it resets to zero.
// - Writing one clears a sticky flag; zero leaves it; always readable.
// - Program status nibble is set and reset by DMA instruction bits.
// - Read-only bit shows DMA engine running; zero when disabled.
// - Ack bit sets on acknowledged transfer, clears on unacknowledged completion.
// - Field parity bit reads current field, zero odd, one even.
// - Sync error flag sets on sync counter overflow or sync mismatch.
// - Opcode error flag sets on reserved opcode or reserved sync status.
// - Abort flag sets on master or target abort as initiator.
// - Instruction fetch parity error sets flag and clears DMA enable when enabled.
// - Bus parity flag sets on any parity error regardless of response.
// - Resync flag sets when FIFO counts disagree with program.
// - Target latency overrun flag sets on overrun with master termination.
// - Word drop overrun flag sets when overrun drops words.
// - Program interrupt flag sets on instruction with interrupt bit.
// - Auxiliary pin flag sets on configured pin edge or level.
// - Serial done flag sets when a serial transfer finishes.
// - Flags for presence toggle, horizontal lock change, converter overflow.
// - Flags for new line, field change and video standard change.
// - Mask bits enable same status flags; bit 23 selects compatibility mode.
// - Interrupt is a level held while any enabled flag is pending.
// - Odd and even capture enables gate the field counter.
// - DMA program enable runs the engine; fetch parity errors clear it when parity response is enabled.
`timescale 1ns/10ps
`include "capture_irq_consts.svh"

module capture_interrupt_status_unit
   import capture_irq_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk_in,
   input  wire logic        resetn_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // DMA engine events
   input  wire logic [3:0]  prog_status_set_in,
   input  wire logic [3:0]  prog_status_reset_in,
   input  wire logic        dma_running_in,
   input  wire logic        sync_overflow_in,
   input  wire logic        sync_mismatch_in,
   input  wire logic        bad_opcode_in,
   input  wire logic        bad_sync_status_in,
   input  wire logic        prog_irq_in,
   input  wire logic        resync_in,
   // PCI events
   input  wire logic        master_abort_in,
   input  wire logic        target_abort_in,
   input  wire logic        fetch_parity_in,
   input  wire logic        parity_resp_en_in,
   input  wire logic        bus_parity_in,
   // FIFO overrun events
   input  wire logic        overrun_target_in,
   input  wire logic        overrun_drop_in,
   // Serial bus, aux pin and decoder events
   input  wire logic        serial_done_in,
   input  wire logic        serial_ack_in,
   input  wire logic        aux_event_in,
   input  wire logic        presence_change_in,
   input  wire logic        horiz_lock_change_change_in,
   input  wire logic        converter_ovf_in,
   input  wire logic        line_start_in,
   input  wire logic        field_change_in,
   input  wire logic        standard_change_in,
   input  wire logic        even_field_in,
   // Outputs to the rest of the device
   output logic             irq_out,
   output logic             host_compat_mode_out,
   output logic [1:0]       capture_enable_out,
   output logic             dma_program_enable_out
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   logic        wr_en;
   logic        known_addr;
   sticky_t     sticky_reg;
   sticky_t     sticky_next;
   sticky_t     sticky_set;
   logic [23:0] mask_reg;
   logic [23:0] mask_next;
   logic [7:0]  field_counter_reg;
   logic [3:0]  prog_status_reg;
   logic        ack_reg;
   logic [1:0]  capture_en_reg;
   logic        dma_enable_reg;
   word_t       status_word;
   word_t       rd_word;

   // Zero-wait slave: every access completes in its first access cycle
   assign pready_out  = 1'b1;
   assign known_addr  = (paddr_in == `ADDR_FIELD_COUNTER) || (paddr_in == `ADDR_INT_STATUS) ||
                        (paddr_in == `ADDR_INT_MASK) || (paddr_in == `ADDR_CAPTURE_CTRL) ||
                        (paddr_in == `ADDR_DMA_CTRL);
   assign pslverr_out = psel_in && penable_in && !known_addr;
   assign wr_en       = psel_in && penable_in && pwrite_in;

   // ------------------------------------------------------------
   // Event collection
   // ------------------------------------------------------------
   // Gather one-cycle event pulses into their status positions
   always_comb
   begin
      sticky_set = '0;
      sticky_set[`ST_SYNC_ERR]    = sync_overflow_in | sync_mismatch_in;
      sticky_set[`ST_OPCODE_ERR]  = bad_opcode_in | bad_sync_status_in;
      sticky_set[`ST_ABORT]       = master_abort_in | target_abort_in;
      sticky_set[`ST_INSTR_PAR]   = fetch_parity_in & parity_resp_en_in;
      sticky_set[`ST_BUS_PAR]     = bus_parity_in;
      sticky_set[`ST_RESYNC]      = resync_in;
      sticky_set[`ST_OVR_TARGET]  = overrun_target_in;
      sticky_set[`ST_OVR_DROP]    = overrun_drop_in;
      sticky_set[`ST_PROG_IRQ]    = prog_irq_in;
      sticky_set[`ST_AUX_PIN]     = aux_event_in;
      sticky_set[`ST_SERIAL_DONE] = serial_done_in;
      sticky_set[`ST_PRESENCE]    = presence_change_in;
      sticky_set[`ST_HORIZ_LOCK_CHANGE]       = horiz_lock_change_change_in;
      sticky_set[`ST_CONV_OVF]    = converter_ovf_in;
      sticky_set[`ST_LINE]        = line_start_in;
      sticky_set[`ST_FIELD_CHG]   = field_change_in;
      sticky_set[`ST_STD_CHG]     = standard_change_in;
   end

   // Set beats clear so an event landing on a clear write is not lost
   always_comb
   begin
      sticky_next = sticky_reg;
      if (wr_en && (paddr_in == `ADDR_INT_STATUS))
      begin
         sticky_next = sticky_next & ~pwdata_in[22:0];
      end
      sticky_next = (sticky_next | sticky_set) & `STICKY_VALID;
   end

   // ------------------------------------------------------------
   // State registers
   // ------------------------------------------------------------
   // Sticky flags
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         sticky_reg <= '0;
      else
         sticky_reg <= sticky_next;
   end

   // Next mask value; the interrupt looks at it so unmasking a pending flag acts at once
   always_comb
   begin
      mask_next = mask_reg;
      if (wr_en && (paddr_in == `ADDR_INT_MASK))
      begin
         mask_next = pwdata_in[23:0];
      end
   end

   // Mask register, including the compatibility bit
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         mask_reg <= `MASK_RESET;
      else
         mask_reg <= mask_next;
   end

   // Field counter; a write of any value clears it
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         field_counter_reg <= `FIELD_CNT_RESET;
      else if (wr_en && (paddr_in == `ADDR_FIELD_COUNTER))
         field_counter_reg <= `FIELD_CNT_RESET;
      else if (field_change_in && (|capture_en_reg))
         field_counter_reg <= field_counter_reg + 8'h01;
   end

   // Program status nibble; set wins over reset on the same bit
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         prog_status_reg <= `PROG_STATUS_RESET;
      else
         prog_status_reg <= (prog_status_reg & ~prog_status_reset_in) | prog_status_set_in;
   end

   // Serial acknowledge; resolved at each transfer completion
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         ack_reg <= 1'b0;
      else if (serial_done_in)
         ack_reg <= serial_ack_in;
   end

   // Capture enables for odd and even fields
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         capture_en_reg <= `CAP_EN_RESET;
      else if (wr_en && (paddr_in == `ADDR_CAPTURE_CTRL))
         capture_en_reg <= pwdata_in[`CAP_EN_HI:0];
   end

   // DMA program enable; a fetch parity error with parity response enabled forces it off over any write
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         dma_enable_reg <= 1'b0;
      else if (fetch_parity_in && parity_resp_en_in)
         dma_enable_reg <= 1'b0;
      else if (wr_en && (paddr_in == `ADDR_DMA_CTRL))
         dma_enable_reg <= pwdata_in[`DMA_EN_BIT];
   end

   // Level interrupt held until all enabled flags are cleared or masked
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         irq_out <= 1'b0;
      else
         irq_out <= |(sticky_next & mask_next[`MASK_IRQ_BITS:0]);
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   // Status word; reserved positions stay zero
   always_comb
   begin
      status_word = `ZERO_WORD;
      status_word[22:0] = sticky_reg;
      status_word[`ST_PROG_HI:`ST_PROG_LO] = prog_status_reg;
      status_word[`ST_DMA_RUN] = dma_running_in & dma_enable_reg;
      status_word[`ST_ACK]     = ack_reg;
      status_word[`ST_FIELD]   = even_field_in;
   end

   // Read multiplexer; unmapped addresses read zero with an error
   always_comb
   begin
      rd_word = `ZERO_WORD;
      unique case (paddr_in)
         `ADDR_FIELD_COUNTER: rd_word[7:0]  = field_counter_reg;
         `ADDR_INT_STATUS:    rd_word       = status_word;
         `ADDR_INT_MASK:      rd_word[23:0] = mask_reg;
         `ADDR_CAPTURE_CTRL:  rd_word[1:0]  = capture_en_reg;
         `ADDR_DMA_CTRL:      rd_word[`DMA_EN_BIT] = dma_enable_reg;
         default:             rd_word       = `ZERO_WORD;
      endcase
   end

   // Read data registered in the setup cycle so it is stable in access
   always_ff @(posedge ref_clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         prdata_out <= `ZERO_WORD;
      else if (psel_in && !penable_in && !pwrite_in)
         prdata_out <= rd_word;
   end

   // Side outputs
   assign host_compat_mode_out   = mask_reg[`MASK_COMPAT_BIT];
   assign capture_enable_out     = capture_en_reg;
   assign dma_program_enable_out = dma_enable_reg;

endmodule

// ===== capture_irq_chk.sv
`timescale 1ns/10ps
`include "capture_irq_consts.svh"
module capture_irq_chk
   import capture_irq_pkg::*;
(
   // Clock, reset and bus
   input wire logic        ref_clk_in,
   input wire logic        resetn_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Events and outputs
   input wire logic        fetch_parity_in,
   input wire logic        parity_resp_en_in,
   input wire logic        standard_change_in,
   input wire logic        irq_out,
   input wire logic        host_compat_mode_out,
   input wire logic [1:0]  capture_enable_out,
   input wire logic        dma_program_enable_out
);
   // ------------------------------------------------------------
   // Port checks
   // ------------------------------------------------------------
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);
   logic        acc;
   logic        stop;
   logic [22:0] mask_reg;
   assign acc  = psel_in && penable_in;
   assign stop = fetch_parity_in && parity_resp_en_in;
   sequence s_wr(a);
      acc && pwrite_in && paddr_in == a;
   endsequence
   // Shadow of the mask, so irq can be judged from the ports alone
   always_ff @(posedge ref_clk_in or negedge resetn_in)
      if (!resetn_in)
         mask_reg <= 23'h000000;
      else if (acc && pwrite_in && paddr_in == `ADDR_INT_MASK)
         mask_reg <= pwdata_in[22:0];
   a_ready_always: assert property (pready_out) else $error("pready low");
   a_err_unmapped: assert property (acc |-> pslverr_out == !(paddr_in inside {`ADDR_FIELD_COUNTER,
      `ADDR_INT_STATUS, `ADDR_INT_MASK, `ADDR_CAPTURE_CTRL, `ADDR_DMA_CTRL}))
      else $error("pslverr wrong");
   a_compat_write: assert property (s_wr(`ADDR_INT_MASK) |=>
      host_compat_mode_out == $past(pwdata_in[23])) else $error("compat bit wrong");
   a_cap_write: assert property (s_wr(`ADDR_CAPTURE_CTRL) |=>
      capture_enable_out == $past(pwdata_in[1:0])) else $error("capture enable wrong");
   a_dma_write: assert property (s_wr(`ADDR_DMA_CTRL) ##0 !stop |=>
      dma_program_enable_out == $past(pwdata_in[1])) else $error("dma enable wrong");
   a_fetch_stop: assert property (stop |=> !dma_program_enable_out)
      else $error("dma not stopped");
   a_irq_masked: assert property (mask_reg == 23'h000000 |-> !irq_out)
      else $error("irq with empty mask");
   a_irq_event: assert property (standard_change_in && mask_reg[0] &&
      !(acc && pwrite_in && paddr_in == `ADDR_INT_MASK) |=> irq_out) else $error("irq missing");
   a_irq_level: assert property (irq_out && !(acc && pwrite_in) |=> irq_out)
      else $error("irq dropped");
   a_resv_zero: assert property (acc && !pwrite_in && paddr_in == `ADDR_INT_STATUS |->
      (prdata_out & 32'h04f004c0) == 32'h00000000) else $error("reserved bit set");
endmodule

// ===== host_irq_model.sv
`timescale 1ns/10ps
module host_irq_model
(
   // Interrupt line as the host sees it
   input  wire logic       ref_clk_in,
   input  wire logic       resetn_in,
   input  wire logic       irq_in,
   output logic      [7:0] rise_count_out
);
   logic irq_reg;
   // Level input: only a new assertion is a new request to service
   always_ff @(posedge ref_clk_in or negedge resetn_in)
      if (!resetn_in)
      begin
         irq_reg        <= 1'b0;
         rise_count_out <= 8'h00;
      end
      else
      begin
         irq_reg <= irq_in;
         if (irq_in && !irq_reg)
            rise_count_out <= rise_count_out + 8'h01;
      end
endmodule

// ===== tb.sv
`timescale 1ns/10ps
`include "capture_irq_consts.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin n_fail++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb;
   import capture_irq_pkg::*;
   logic        ref_clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
   logic        dma_running_in, parity_resp_en_in, serial_ack_in, even_field_in, irq_out;
   logic        host_compat_mode_out, dma_program_enable_out, err, ack_e, run_e, ab;
   logic [11:0] paddr_in;
   word_t       pwdata_in, prdata_out, rd_d, d;
   logic [3:0]  prog_status_set_in, prog_status_reset_in, prog, v, r;
   logic [1:0]  capture_enable_out;
   logic [19:0] src, fl;
   logic [7:0]  rises;
   int          n_fail, total_checks, cyc, exp_rises, n;
   localparam int BIT_OF[20] = '{0, 1, 2, 3, 4, 5, 8, 9, 11, 12, 13, 14, 15, 16, 17, 17, 18, 18,
      19, 19};
   // ------------------------------------------------------------
   // Design, host model and clock
   // ------------------------------------------------------------
   capture_interrupt_status_unit dut_u (.*,
      .standard_change_in(src[0]), .field_change_in(src[1]), .line_start_in(src[2]),
      .converter_ovf_in(src[3]), .horiz_lock_change_change_in(src[4]), .presence_change_in(src[5]),
      .serial_done_in(src[6]), .aux_event_in(src[7]), .prog_irq_in(src[8]),
      .overrun_drop_in(src[9]), .overrun_target_in(src[10]), .resync_in(src[11]),
      .bus_parity_in(src[12]), .fetch_parity_in(src[13]), .master_abort_in(src[14]),
      .target_abort_in(src[15]), .bad_opcode_in(src[16]), .bad_sync_status_in(src[17]),
      .sync_overflow_in(src[18]), .sync_mismatch_in(src[19]));
   host_irq_model host_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .irq_in(irq_out),
      .rise_count_out(rises));
   initial
   begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end
   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         n_fail++;
         report_and_stop();
      end
   end
   // Expected status word from the bench's own flag model
   function automatic word_t stat();
      return {prog, run_e, 1'b0, ack_e, even_field_in, 4'h0, fl};
   endfunction
   // One APB transfer; ev >= 0 fires that event on the edge the access is taken
   task automatic apb(input logic w, input logic [11:0] a, input word_t dw, input int ev);
      @(posedge ref_clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= dw;
      @(posedge ref_clk_in);
      penable_in <= 1'b1;
      if (ev >= 0) src[ev] <= 1'b1;
      @(posedge ref_clk_in);
      while (pready_out !== 1'b1) @(posedge ref_clk_in);
      rd_d = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      src <= 20'h00000;
   endtask
   task automatic pulse(input int i);
      @(posedge ref_clk_in);
      src[i] <= 1'b1;
      @(posedge ref_clk_in);
      src[i] <= 1'b0;
   endtask
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      void'($urandom(9));
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, src} = '0;
      {prog_status_set_in, prog_status_reset_in, dma_running_in, serial_ack_in} = '0;
      {prog, fl, ack_e, run_e, exp_rises} = '0;
      parity_resp_en_in = 1'b1;
      even_field_in = 1'($urandom % 2);
      resetn_in = 1'b0;
      repeat (12) @(posedge ref_clk_in);
      resetn_in <= 1'b1;
      apb(0, `ADDR_FIELD_COUNTER, 0, -1);
      `CHK("field count", 32'h0, rd_d)
      apb(0, `ADDR_INT_MASK, 0, -1);
      `CHK("mask", 32'h0, rd_d)
      apb(1, 12'h0f0, $urandom, -1);
      apb(0, 12'h0f0, 0, -1);
      `CHK("unmapped", 32'h0, rd_d)
      `CHK("slverr", 1'b1, err)
      for (int i = 0; i < 20; i++)
      begin
         ab = 1'($urandom % 2);
         serial_ack_in <= ab;
         if (i == 6) ack_e = ab;
         pulse(i);
         fl[BIT_OF[i]] = 1'b1;
         apb(0, `ADDR_INT_STATUS, 0, -1);
         `CHK("status set", stat(), rd_d)
         d = $urandom & ~(32'h1 << BIT_OF[i]);
         apb(1, `ADDR_INT_STATUS, d, -1);
         fl = fl & ~d[19:0];
         apb(0, `ADDR_INT_STATUS, 0, -1);
         `CHK("status kept", stat(), rd_d)
         apb(1, `ADDR_INT_STATUS, 32'h1 << BIT_OF[i], -1);
         fl[BIT_OF[i]] = 1'b0;
      end
      apb(1, `ADDR_INT_MASK, 32'h00800001, -1);
      @(negedge ref_clk_in);
      `CHK("compat", 1'b1, host_compat_mode_out)
      pulse(0);
      fl[0] = 1'b1;
      exp_rises++;
      @(negedge ref_clk_in);
      `CHK("irq on", 1'b1, irq_out)
      apb(1, `ADDR_INT_MASK, 0, -1);
      @(negedge ref_clk_in);
      `CHK("irq masked", 1'b0, irq_out)
      apb(1, `ADDR_INT_MASK, 1, -1);
      exp_rises++;
      @(negedge ref_clk_in);
      `CHK("irq unmask", 1'b1, irq_out)
      apb(1, `ADDR_INT_STATUS, 1, 0);
      @(negedge ref_clk_in);
      `CHK("set wins", 1'b1, irq_out)
      apb(1, `ADDR_INT_STATUS, 1, -1);
      fl[0] = 1'b0;
      @(negedge ref_clk_in);
      `CHK("irq clear", 1'b0, irq_out)
      `CHK("host rises", exp_rises[7:0], rises)
      apb(1, `ADDR_CAPTURE_CTRL, 32'h1 << ($urandom % 2), -1);
      n = 1 + $urandom % 6;
      repeat (n) pulse(1);
      apb(1, `ADDR_CAPTURE_CTRL, 0, -1);
      pulse(1);
      apb(0, `ADDR_FIELD_COUNTER, 0, -1);
      `CHK("field count", n, rd_d)
      apb(1, `ADDR_FIELD_COUNTER, $urandom, -1);
      apb(0, `ADDR_FIELD_COUNTER, 0, -1);
      `CHK("count clear", 32'h0, rd_d)
      apb(1, `ADDR_INT_STATUS, 32'hffffffff, -1);
      fl = '0;
      repeat (3)
      begin
         v = 4'($urandom);
         r = 4'($urandom);
         @(posedge ref_clk_in);
         prog_status_set_in <= v;
         prog_status_reset_in <= r;
         @(posedge ref_clk_in);
         prog_status_set_in <= 4'h0;
         prog_status_reset_in <= 4'h0;
         prog = (prog & ~r) | v;
      end
      apb(1, `ADDR_DMA_CTRL, 32'h2, -1);
      dma_running_in <= 1'b1;
      run_e = 1'b1;
      apb(0, `ADDR_INT_STATUS, 0, -1);
      `CHK("prog run", stat(), rd_d)
      pulse(13);
      fl[16] = 1'b1;
      run_e = 1'b0;
      @(negedge ref_clk_in);
      `CHK("dma stop", 1'b0, dma_program_enable_out)
      apb(0, `ADDR_INT_STATUS, 0, -1);
      `CHK("run off", stat(), rd_d)
      parity_resp_en_in <= 1'b0;
      apb(1, `ADDR_INT_STATUS, 32'hffffffff, -1);
      fl = '0;
      apb(1, `ADDR_DMA_CTRL, 32'h2, -1);
      run_e = 1'b1;
      pulse(13);
      pulse(12);
      fl[15] = 1'b1;
      apb(0, `ADDR_INT_STATUS, 0, -1);
      `CHK("no resp", stat(), rd_d)
      report_and_stop();
   end
endmodule
bind capture_interrupt_status_unit capture_irq_chk chk_u (.*);
